// File: core/rwre_core.v
// Behaviour
// - wait three slot times for reply
// - resend until programmed retry limit
// - underrun counts as one attempt
// - queue reply, link pointer, positive confirmation
// - completion sets request done flag
// - exhausted retries give negative confirmation
// - valid reply: response data, first frame
// - other frame: negative confirm, unexpected flags
// - copy source address into reply destination
// - new request updates pointer and flag
// - retry only when directly after request
// - predefined mode sends reply at silence
// - otherwise wait for host reply ready
// - late ready answers the next retry
// - owed reply freezes pointer and flag
// - ready during reception executes after frame
// - device acts as master or slave
// - good frames addressed here go to their class queue
`timescale 1ns/1ns
`include "rwre_defines.vh"

module rwre_core (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // register port
    input wire [9:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_q,
    // host commands
    input wire cmd_set_predef,
    input wire cmd_predef_val,
    input wire cmd_reply_ready,
    // transmitter events
    input wire tx_req_sent,
    input wire tx_underrun,
    input wire [31:0] tx_req_fd,
    output reg tx_resend_q,
    output reg tx_reply_q,
    output reg [31:0] tx_reply_ptr_q,
    // receiver events
    input wire rx_busy,
    input wire rx_done,
    input wire rx_ok,
    input wire rx_llc_data,
    input wire rx_resp_action,
    input wire rx_req_action,
    input wire rx_to_us,
    input wire [1:0] rx_class,
    input wire [31:0] rx_fd,
    input wire [47:0] rx_src,
    input wire medium_silent,
    // receive queue store
    output reg rxq_store_q,
    output reg [1:0] rxq_class_q,
    output reg [31:0] rxq_fd_q,
    // descriptor writes
    output reg conf_valid_q,
    output reg [31:0] conf_fd_q,
    output reg [1:0] conf_code_q,
    output reg [31:0] conf_link_q,
    output reg da_wr_q,
    output reg [31:0] da_ptr_q,
    output reg [47:0] da_val_q,
    // status word events
    output reg ev_request_done_q,
    output reg ev_received_request_q,
    output reg ev_reply_sent_q,
    output reg ev_unexpected_q
);

// ----------------------------------------
// decode and registers
// ----------------------------------------
function is_idx;
    input [9:0] addr;
    input [7:0] idx;
    begin
        is_idx = (addr == {idx, 2'b00});
    end
endfunction

reg [7:0] retry_limit_q;
reg [31:0] reply_dest_q;
reg [31:0] reply_ptr_q;
reg [31:0] rxreq_ptr_q;
reg [15:0] slot_cycles_q;
reg predef_q;

reg [1:0] rq_state_q;
reg [1:0] rq_state_d;
reg [31:0] req_fd_q;

reg owed_q;
reg last_req_q;
reg late_armed_q;
reg send_pend_q;
reg ready_defer_q;

reg silent_meta_q;
reg silent_q;

wire window_running;
wire window_expired;
wire deadline_running;
wire deadline_expired;
wire [7:0] retry_count;
wire at_limit;

// frame classification
wire frame_in = rx_done && rx_ok;
wire valid_reply = frame_in && rx_llc_data && rx_resp_action && rx_to_us;
wire req_here = frame_in && rx_llc_data && rx_req_action && rx_to_us;
wire is_retry = req_here && last_req_q;
wire ready_now = (cmd_reply_ready && !rx_busy) || (ready_defer_q && !rx_busy);

// requester control terms
wire win_timeout = (rq_state_q == `RWRE_RQ_WAIT) && window_expired && !frame_in;
wire attempt_fail = win_timeout || (tx_underrun && rq_state_q != `RWRE_RQ_WAIT);
wire give_up = attempt_fail && at_limit;
wire rq_reply = (rq_state_q == `RWRE_RQ_WAIT) && valid_reply;
wire rq_unexp = (rq_state_q == `RWRE_RQ_WAIT) && frame_in && !valid_reply;
wire win_start = tx_req_sent && rq_state_q != `RWRE_RQ_WAIT;

// ----------------------------------------
// medium silence synchroniser
// ----------------------------------------
always @(posedge ref_clk) begin
    if (!rst_n) begin
        silent_meta_q <= 1'b0;
        silent_q <= 1'b0;
    end else begin
        silent_meta_q <= medium_silent;
        silent_q <= silent_meta_q;
    end
end

// ----------------------------------------
// timers and retry counter
// ----------------------------------------
// three slot reply window
rwre_slot_timer #(
    .NSLOTS(`RWRE_REPLY_WINDOW_SLOTS)
) u_window (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(win_start),
    .stop(rq_reply || rq_unexp),
    .slot_cycles(slot_cycles_q),
    .running_q(window_running),
    .expired_q(window_expired)
);

rwre_slot_timer #(
    .NSLOTS(`RWRE_REPLY_DEADLINE_SLOTS)
) u_deadline (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(req_here),
    .stop(1'b0),
    .slot_cycles(slot_cycles_q),
    .running_q(deadline_running),
    .expired_q(deadline_expired)
);

rwre_retry_ctr u_retry (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(give_up || rq_reply || rq_unexp),
    .inc(attempt_fail && !at_limit),
    .limit(retry_limit_q),
    .count_q(retry_count),
    .at_limit(at_limit)
);

// ----------------------------------------
// register port
// ----------------------------------------
// slave access to the tables
always @(posedge ref_clk) begin
    if (!rst_n) begin
        retry_limit_q <= `RWRE_RETRY_RESET;
        reply_dest_q <= `RWRE_PTR_RESET;
        reply_ptr_q <= `RWRE_PTR_RESET;
        slot_cycles_q <= `RWRE_SLOT_RESET;
        predef_q <= 1'b0;
        reg_rdata_q <= 32'h00000000;
    end else begin
        if (reg_wr && is_idx(reg_addr, `RWRE_IDX_RETRY_LIMIT)) begin
            retry_limit_q <= reg_wdata[7:0];
        end
        if (reg_wr && is_idx(reg_addr, `RWRE_IDX_REPLY_DEST)) begin
            reply_dest_q <= reg_wdata;
        end
        if (reg_wr && is_idx(reg_addr, `RWRE_IDX_REPLY_PTR)) begin
            reply_ptr_q <= reg_wdata;
        end
        if (reg_wr && is_idx(reg_addr, `RWRE_IDX_SLOT)) begin
            slot_cycles_q <= reg_wdata[15:0];
        end
        if (cmd_set_predef) begin
            predef_q <= cmd_predef_val;
        end else if (reg_wr && is_idx(reg_addr, `RWRE_IDX_CTRL)) begin
            predef_q <= reg_wdata[`RWRE_CTRL_PREDEF_BIT];
        end
        reg_rdata_q <= 32'h00000000;
        if (reg_rd) begin
            if (is_idx(reg_addr, `RWRE_IDX_RETRY_LIMIT)) begin
                reg_rdata_q <= {24'h000000, retry_limit_q};
            end else if (is_idx(reg_addr, `RWRE_IDX_REPLY_DEST)) begin
                reg_rdata_q <= reply_dest_q;
            end else if (is_idx(reg_addr, `RWRE_IDX_REPLY_PTR)) begin
                reg_rdata_q <= reply_ptr_q;
            end else if (is_idx(reg_addr, `RWRE_IDX_RXREQ_PTR)) begin
                reg_rdata_q <= rxreq_ptr_q;
            end else if (is_idx(reg_addr, `RWRE_IDX_CTRL)) begin
                reg_rdata_q <= {31'h0, predef_q};
            end else if (is_idx(reg_addr, `RWRE_IDX_SLOT)) begin
                reg_rdata_q <= {16'h0000, slot_cycles_q};
            end else if (is_idx(reg_addr, `RWRE_IDX_STATUS)) begin
                reg_rdata_q <= {16'h0000, retry_count, window_running, deadline_running,
                                late_armed_q, send_pend_q, owed_q, last_req_q, rq_state_q};
            end
        end
    end
end

// ----------------------------------------
// requester state machine
// ----------------------------------------
always @* begin
    rq_state_d = rq_state_q;
    case (rq_state_q)
        `RWRE_RQ_IDLE: begin
            if (tx_req_sent) begin
                rq_state_d = `RWRE_RQ_WAIT;
            end else if (tx_underrun && !at_limit) begin
                rq_state_d = `RWRE_RQ_SEND;
            end
        end
        `RWRE_RQ_SEND: begin
            if (tx_req_sent) begin
                rq_state_d = `RWRE_RQ_WAIT;
            end else if (give_up) begin
                rq_state_d = `RWRE_RQ_IDLE;
            end
        end
        `RWRE_RQ_WAIT: begin
            if (rq_reply || rq_unexp || give_up) begin
                rq_state_d = `RWRE_RQ_IDLE;
            end else if (win_timeout) begin
                rq_state_d = `RWRE_RQ_SEND;
            end
        end
        default: begin
            rq_state_d = `RWRE_RQ_IDLE;
        end
    endcase
end

always @(posedge ref_clk) begin
    if (!rst_n) begin
        rq_state_q <= `RWRE_RQ_IDLE;
        req_fd_q <= 32'h00000000;
        tx_resend_q <= 1'b0;
        conf_valid_q <= 1'b0;
        conf_fd_q <= 32'h00000000;
        conf_code_q <= 2'h0;
        conf_link_q <= 32'h00000000;
        ev_request_done_q <= 1'b0;
        ev_unexpected_q <= 1'b0;
    end else begin
        rq_state_q <= rq_state_d;
        if ((tx_req_sent || tx_underrun) && rq_state_q == `RWRE_RQ_IDLE) begin
            req_fd_q <= tx_req_fd;
        end
        tx_resend_q <= attempt_fail && !at_limit;
        conf_valid_q <= rq_reply || rq_unexp || give_up;
        conf_fd_q <= (rq_state_q == `RWRE_RQ_IDLE) ? tx_req_fd : req_fd_q;
        conf_link_q <= rq_reply ? rx_fd : 32'h00000000;
        // only a leading response is valid
        if (rq_reply) begin
            conf_code_q <= `RWRE_CONF_POS;
        end else if (rq_unexp) begin
            conf_code_q <= `RWRE_CONF_NEG_UNEXP;
        end else begin
            conf_code_q <= `RWRE_CONF_NEG;
        end
        ev_request_done_q <= rq_reply || rq_unexp || give_up;
        ev_unexpected_q <= rq_unexp;
    end
end

// ----------------------------------------
// receive queue store
// ----------------------------------------
// class queue selection
always @(posedge ref_clk) begin
    if (!rst_n) begin
        rxq_store_q <= 1'b0;
        rxq_class_q <= 2'h0;
        rxq_fd_q <= 32'h00000000;
    end else begin
        rxq_store_q <= frame_in && rx_to_us;
        rxq_class_q <= rx_class;
        rxq_fd_q <= rx_fd;
    end
end

// ----------------------------------------
// responder
// ----------------------------------------
always @(posedge ref_clk) begin
    if (!rst_n) begin
        rxreq_ptr_q <= `RWRE_PTR_RESET;
        owed_q <= 1'b0;
        last_req_q <= 1'b0;
        late_armed_q <= 1'b0;
        send_pend_q <= 1'b0;
        ready_defer_q <= 1'b0;
        da_wr_q <= 1'b0;
        da_ptr_q <= 32'h00000000;
        da_val_q <= 48'h000000000000;
        tx_reply_q <= 1'b0;
        tx_reply_ptr_q <= 32'h00000000;
        ev_received_request_q <= 1'b0;
        ev_reply_sent_q <= 1'b0;
    end else begin
        if (frame_in) begin
            last_req_q <= req_here;
        end
        da_wr_q <= req_here;
        da_ptr_q <= reply_dest_q;
        da_val_q <= rx_src;
        ev_received_request_q <= req_here && !is_retry && !owed_q;
        if (req_here && !is_retry && !owed_q) begin
            rxreq_ptr_q <= rx_fd;
        end else if (reg_wr && is_idx(reg_addr, `RWRE_IDX_RXREQ_PTR)) begin
            rxreq_ptr_q <= reg_wdata;
        end
        if (cmd_reply_ready && rx_busy) begin
            ready_defer_q <= 1'b1;
        end else if (!rx_busy) begin
            ready_defer_q <= 1'b0;
        end
        tx_reply_q <= 1'b0;
        ev_reply_sent_q <= 1'b0;
        if (send_pend_q && silent_q) begin
            tx_reply_q <= 1'b1;
            tx_reply_ptr_q <= reply_ptr_q;
            ev_reply_sent_q <= 1'b1;
            send_pend_q <= 1'b0;
        end
        if (predef_q) begin
            owed_q <= 1'b0;
            late_armed_q <= 1'b0;
            if (req_here) begin
                send_pend_q <= 1'b1;
            end
        end else if (req_here && late_armed_q) begin
            send_pend_q <= 1'b1;
            late_armed_q <= 1'b0;
            owed_q <= 1'b0;
        end else if (ready_now && (owed_q || req_here)) begin
            // ready after the reply deadline has expired arms the late answer, otherwise the reply is sent at the next medium silence
            if (deadline_expired && !deadline_running && !req_here) begin
                late_armed_q <= 1'b1;
            end else begin
                send_pend_q <= 1'b1;
                owed_q <= 1'b0;
            end
        end else if (req_here) begin
            owed_q <= 1'b1;
        end
    end
end

endmodule // rwre_core

// File: core/rwre_defines.vh
`ifndef RWRE_DEFINES_VH
`define RWRE_DEFINES_VH

// ----------------------------------------
// register indices, byte address is index times four
// ----------------------------------------
`define RWRE_IDX_RETRY_LIMIT 8'h6E
`define RWRE_IDX_REPLY_DEST 8'h84
`define RWRE_IDX_REPLY_PTR 8'h88
`define RWRE_IDX_RXREQ_PTR 8'h8C
`define RWRE_IDX_CTRL 8'h90
`define RWRE_IDX_SLOT 8'h91
`define RWRE_IDX_STATUS 8'h92

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define RWRE_CTRL_PREDEF_BIT 0
`define RWRE_RETRY_RESET 8'h07
`define RWRE_SLOT_RESET 16'h0040
`define RWRE_PTR_RESET 32'h00000000

// ----------------------------------------
// timing in slot times
// ----------------------------------------
`define RWRE_REPLY_WINDOW_SLOTS 3
`define RWRE_REPLY_DEADLINE_SLOTS 2

// ----------------------------------------
// confirmation codes and requester states
// ----------------------------------------
`define RWRE_CONF_POS 2'h1
`define RWRE_CONF_NEG 2'h2
`define RWRE_CONF_NEG_UNEXP 2'h3
`define RWRE_RQ_IDLE 2'h0
`define RWRE_RQ_SEND 2'h1
`define RWRE_RQ_WAIT 2'h2

`endif

// File: core/rwre_retry_ctr.v
`timescale 1ns/1ns

module rwre_retry_ctr (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // control
    input wire clear,
    input wire inc,
    input wire [7:0] limit,
    // status
    output reg [7:0] count_q,
    output wire at_limit
);

// ----------------------------------------
// attempt counter
// ----------------------------------------
assign at_limit = (count_q >= limit);

always @(posedge ref_clk) begin
    if (!rst_n) begin
        count_q <= 8'h00;
    end else if (clear) begin
        count_q <= 8'h00;
    end else if (inc && count_q != 8'hFF) begin
        count_q <= count_q + 8'h01;
    end
end

endmodule // rwre_retry_ctr

// File: core/rwre_slot_timer.v
`timescale 1ns/1ns
`include "rwre_defines.vh"

module rwre_slot_timer #(
    parameter NSLOTS = 3
) (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // control
    input wire start,
    input wire stop,
    input wire [15:0] slot_cycles,
    // status
    output reg running_q,
    output reg expired_q
);

reg [15:0] cyc_q;
reg [3:0] slot_q;

// ----------------------------------------
// counts slot times, restart wins over stop
// ----------------------------------------
always @(posedge ref_clk) begin
    if (!rst_n) begin
        running_q <= 1'b0;
        expired_q <= 1'b0;
        cyc_q <= 16'h0000;
        slot_q <= 4'h0;
    end else if (start) begin
        running_q <= 1'b1;
        expired_q <= 1'b0;
        cyc_q <= 16'h0000;
        slot_q <= 4'h0;
    end else if (stop) begin
        running_q <= 1'b0;
    end else if (running_q) begin
        if (cyc_q + 16'h0001 >= slot_cycles) begin
            cyc_q <= 16'h0000;
            if (slot_q == NSLOTS[3:0] - 4'h1) begin
                running_q <= 1'b0;
                expired_q <= 1'b1;
            end else begin
                slot_q <= slot_q + 4'h1;
            end
        end else begin
            cyc_q <= cyc_q + 16'h0001;
        end
    end
end

endmodule // rwre_slot_timer

// File: dv/rwre_core_monitor.sv
`timescale 1ns/1ns
module rwre_core_monitor (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // inputs seen
    input wire reg_rd,
    input wire rx_done,
    input wire rx_ok,
    input wire rx_llc_data,
    input wire rx_req_action,
    input wire rx_to_us,
    input wire [31:0] rx_fd,
    input wire [47:0] rx_src,
    input wire medium_silent,
    // outputs seen
    input wire [31:0] reg_rdata_q,
    input wire tx_reply_q,
    input wire rxq_store_q,
    input wire conf_valid_q,
    input wire [1:0] conf_code_q,
    input wire [31:0] conf_link_q,
    input wire da_wr_q,
    input wire [47:0] da_val_q,
    input wire ev_request_done_q,
    input wire ev_received_request_q,
    input wire ev_reply_sent_q,
    input wire ev_unexpected_q
);
    wire req_in;
    assign req_in = rx_done & rx_ok & rx_llc_data & rx_req_action & rx_to_us;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ----------------
    // properties
    // ----------------
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0)
        else $error("read data outside answer cycle");
    req_store_a: assert property (req_in |=> rxq_store_q && da_wr_q && da_val_q == $past(rx_src))
        else $error("request not stored or source not copied");
    rxreq_ev_a: assert property (ev_received_request_q |-> da_wr_q && rxq_store_q)
        else $error("received request flag without request");
    done_pair_a: assert property (conf_valid_q |-> ev_request_done_q)
        else $error("confirmation without done flag");
    neg_link_a: assert property (conf_valid_q && conf_code_q != 2'h1 |-> conf_link_q == 32'h0)
        else $error("negative confirmation links a reply");
    pos_link_a: assert property (conf_valid_q && conf_code_q == 2'h1 |-> $past(rx_done) && conf_link_q == $past(rx_fd))
        else $error("positive confirmation link wrong");
    unexp_conf_a: assert property (ev_unexpected_q |-> conf_valid_q && conf_code_q == 2'h3)
        else $error("unexpected flag without its confirmation");
    sent_pair_a: assert property (tx_reply_q |-> ev_reply_sent_q && $past(medium_silent, 2))
        else $error("reply sent without silence or flag");
    cover property (conf_valid_q && conf_code_q == 2'h1);
    cover property (conf_valid_q && conf_code_q == 2'h2);
    cover property (ev_unexpected_q);
    cover property (tx_reply_q);
endmodule // rwre_core_monitor

bind rwre_core rwre_core_monitor mon (.ref_clk, .rst_n, .reg_rd, .rx_done, .rx_ok, .rx_llc_data,
    .rx_req_action, .rx_to_us, .rx_fd, .rx_src, .medium_silent, .reg_rdata_q, .tx_reply_q, .rxq_store_q,
    .conf_valid_q, .conf_code_q, .conf_link_q, .da_wr_q, .da_val_q, .ev_request_done_q,
    .ev_received_request_q, .ev_reply_sent_q, .ev_unexpected_q);

// File: dv/rwre_core_tb.sv
`timescale 1ns/1ns
`include "rwre_defines.vh"
module rwre_core_tb;
    localparam SLOT = 4;
    localparam W = `RWRE_REPLY_WINDOW_SLOTS * SLOT;
    reg ref_clk = 1'b0;
    reg rst_n = 1'b0;
    reg [9:0] reg_addr = 10'h0;
    reg [31:0] reg_wdata = 32'h0;
    reg reg_wr = 1'b0, reg_rd = 1'b0, cmd_set_predef = 1'b0, cmd_predef_val = 1'b0;
    reg cmd_reply_ready = 1'b0, b_sent = 1'b0, fail_next = 1'b0, rx_busy = 1'b0, rx_done = 1'b0;
    reg rx_ok = 1'b1, rx_llc_data = 1'b0, rx_resp_action = 1'b0, rx_req_action = 1'b0, rx_to_us = 1'b0;
    reg [1:0] rx_class = 2'h0;
    reg [31:0] tx_req_fd = 32'h0, rx_fd = 32'h0;
    reg [47:0] rx_src = 48'h0;
    wire m_sent, tx_underrun, on_air, tx_resend_q, tx_reply_q, rxq_store_q, conf_valid_q, da_wr_q;
    wire ev_request_done_q, ev_received_request_q, ev_reply_sent_q, ev_unexpected_q;
    wire [31:0] reg_rdata_q, tx_reply_ptr_q, rxq_fd_q, conf_fd_q, conf_link_q, da_ptr_q;
    wire [47:0] da_val_q;
    wire [1:0] rxq_class_q, conf_code_q;
    wire tx_req_sent = b_sent | m_sent;
    wire medium_silent = !(rx_busy | on_air);
    integer n_mismatch = 0, n_checks = 0, cyc = 0, t0 = 0, t_res = 0, n_resend = 0, n_conf = 0;
    integer n_reply = 0, n_rxreq = 0, n_unexp = 0, n_sent = 0;
    reg [1:0] c_code, q_cls;
    reg [31:0] c_link, c_fd, r_ptr, q_fd, d_ptr;
    reg [47:0] d_val;

    always #20 ref_clk = ~ref_clk;

    rwre_core dut (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
        .cmd_set_predef, .cmd_predef_val, .cmd_reply_ready, .tx_req_sent, .tx_underrun, .tx_req_fd,
        .tx_resend_q, .tx_reply_q, .tx_reply_ptr_q, .rx_busy, .rx_done, .rx_ok, .rx_llc_data,
        .rx_resp_action, .rx_req_action, .rx_to_us, .rx_class, .rx_fd, .rx_src, .medium_silent,
        .rxq_store_q, .rxq_class_q, .rxq_fd_q, .conf_valid_q, .conf_fd_q, .conf_code_q, .conf_link_q,
        .da_wr_q, .da_ptr_q, .da_val_q, .ev_request_done_q, .ev_received_request_q,
        .ev_reply_sent_q, .ev_unexpected_q);
    rwre_medium_model #(.SEND_DLY(3)) partner (.ref_clk, .rst_n, .tx_resend_q, .tx_reply_q,
        .fail_next, .sent_q(m_sent), .underrun_q(tx_underrun), .on_air(on_air));

    // ----------------
    // event tally
    // ----------------
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (b_sent === 1'b1) t0 = cyc;
        if (tx_resend_q === 1'b1) begin
            if (n_resend == 0) t_res = cyc;
            n_resend = n_resend + 1;
        end
        if (conf_valid_q === 1'b1) begin
            n_conf = n_conf + 1;
            c_code = conf_code_q;
            c_link = conf_link_q;
            c_fd = conf_fd_q;
        end
        if (tx_reply_q === 1'b1) begin
            n_reply = n_reply + 1;
            r_ptr = tx_reply_ptr_q;
        end
        if (ev_reply_sent_q === 1'b1) n_sent = n_sent + 1;
        if (ev_received_request_q === 1'b1) n_rxreq = n_rxreq + 1;
        if (ev_unexpected_q === 1'b1) n_unexp = n_unexp + 1;
        if (rxq_store_q === 1'b1) begin
            q_cls = rxq_class_q;
            q_fd = rxq_fd_q;
        end
        if (da_wr_q === 1'b1) begin
            d_ptr = da_ptr_q;
            d_val = da_val_q;
        end
        if (cyc == 5000) begin
            n_mismatch = n_mismatch + 1;
            print_verdict;
        end
    end

    // ----------------
    // tasks
    // ----------------
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", n_checks, n_mismatch);
            if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    task chk(input [63:0] got, input [63:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("Error at %0t: got %0h expected %0h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] i, input [31:0] d);
        begin
            reg_wr <= 1'b1;
            reg_addr <= {i, 2'h0};
            reg_wdata <= d;
            @(posedge ref_clk);
            reg_wr <= 1'b0;
            @(posedge ref_clk);
        end
    endtask
    task rd(input [7:0] i, input [31:0] e);
        begin
            reg_rd <= 1'b1;
            reg_addr <= {i, 2'h0};
            @(posedge ref_clk);
            reg_rd <= 1'b0;
            #1 chk(reg_rdata_q, e);
        end
    endtask
    task cmd(input s, input v, input r);
        begin
            cmd_set_predef <= s;
            cmd_predef_val <= v;
            cmd_reply_ready <= r;
            @(posedge ref_clk);
            cmd_set_predef <= 1'b0;
            cmd_reply_ready <= 1'b0;
        end
    endtask
    task req(input [31:0] fd);
        begin
            n_resend = 0;
            tx_req_fd <= fd;
            b_sent <= 1'b1;
            @(posedge ref_clk);
            b_sent <= 1'b0;
        end
    endtask
    // frame bits: llc data, response, request, addressed here
    task frame(input [3:0] f, input [31:0] fd, input rdy);
        begin
            rx_busy <= 1'b1;
            if (rdy) cmd_reply_ready <= 1'b1;
            @(posedge ref_clk);
            cmd_reply_ready <= 1'b0;
            repeat (2) @(posedge ref_clk);
            {rx_llc_data, rx_resp_action, rx_req_action, rx_to_us} <= f;
            rx_busy <= 1'b0;
            rx_done <= 1'b1;
            rx_class <= fd[3:2];
            rx_fd <= fd;
            rx_src <= {16'hA5A5, fd};
            @(posedge ref_clk);
            rx_done <= 1'b0;
            repeat (2) @(posedge ref_clk);
        end
    endtask
    task settle;
        integer k;
        begin
            k = n_conf + n_reply;
            repeat (200) if (n_conf + n_reply == k) @(posedge ref_clk);
            repeat (2) @(posedge ref_clk);
        end
    endtask

    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rd(8'h6E, 32'h7);
        rd(8'h8C, 32'h0);
        wr(8'hFF, 32'h5);
        rd(8'hFF, 32'h0);
        wr(8'h6E, 32'h2);
        wr(8'h91, SLOT);
        wr(8'h84, 32'h100);
        wr(8'h88, 32'h100);
        rd(8'h84, 32'h100);
        $display("registers done");
        req(32'hA0);
        settle;
        chk(n_resend, 2);
        chk(c_code, `RWRE_CONF_NEG);
        chk(c_fd, 32'hA0);
        chk(t_res - t0 >= W && t_res - t0 <= W + 3, 1);
        wr(8'h6E, 32'h1);
        fail_next <= 1'b1;
        req(32'hA4);
        settle;
        fail_next <= 1'b0;
        chk(n_resend, 1);
        chk(c_code, `RWRE_CONF_NEG);
        wr(8'h6E, 32'h2);
        req(32'hB0);
        frame(4'hD, 32'hC8, 1'b0);
        settle;
        chk(c_code, `RWRE_CONF_POS);
        chk({c_fd, c_link}, {32'hB0, 32'hC8});
        chk({q_cls, q_fd}, {2'h2, 32'hC8});
        req(32'hB4);
        frame(4'h9, 32'hCC, 1'b0);
        settle;
        chk(c_code, `RWRE_CONF_NEG_UNEXP);
        chk({n_unexp, q_cls}, {32'h1, 2'h3});
        $display("requester done");
        cmd(1'b1, 1'b0, 1'b0);
        frame(4'hB, 32'hD0, 1'b0);
        cmd(1'b0, 1'b0, 1'b1);
        chk(d_ptr, 32'h100);
        chk(d_val, {16'hA5A5, 32'hD0});
        chk(n_rxreq, 1);
        rd(8'h8C, 32'hD0);
        settle;
        chk({n_reply, r_ptr}, {32'h1, 32'h100});
        frame(4'hB, 32'hD4, 1'b0);
        cmd(1'b0, 1'b0, 1'b1);
        settle;
        chk(n_rxreq, 1);
        rd(8'h8C, 32'hD0);
        frame(4'h9, 32'hE0, 1'b0);
        frame(4'hB, 32'hD8, 1'b0);
        chk(n_rxreq, 2);
        frame(4'h9, 32'hE4, 1'b0);
        frame(4'hB, 32'hDC, 1'b0);
        chk(n_rxreq, 2);
        rd(8'h8C, 32'hD8);
        repeat (W) @(posedge ref_clk);
        cmd(1'b0, 1'b0, 1'b1);
        repeat (W) @(posedge ref_clk);
        chk(n_reply, 2);
        frame(4'hB, 32'hDC, 1'b0);
        settle;
        chk(n_reply, 3);
        frame(4'h9, 32'hE8, 1'b0);
        frame(4'hB, 32'hC0, 1'b1);
        settle;
        chk(n_reply, 4);
        wr(8'h84, 32'h200);
        cmd(1'b1, 1'b1, 1'b0);
        rd(8'h90, 32'h1);
        frame(4'h9, 32'hEC, 1'b0);
        frame(4'hB, 32'hC4, 1'b0);
        settle;
        chk({n_reply, n_sent, r_ptr}, {32'h5, 32'h5, 32'h100});
        chk(d_ptr, 32'h200);
        $display("responder done");
        print_verdict;
    end
endmodule // rwre_core_tb

// File: dv/rwre_medium_model.sv
`timescale 1ns/1ns
module rwre_medium_model #(
    parameter SEND_DLY = 3
) (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // frames to send
    input wire tx_resend_q,
    input wire tx_reply_q,
    input wire fail_next,
    // results
    output reg sent_q,
    output reg underrun_q,
    output wire on_air
);
    reg [3:0] cnt_q;
    reg resend_q;
    assign on_air = cnt_q != 4'h0;
    // frame holds the medium, then reports the end of a resent frame
    always @(posedge ref_clk) begin
        sent_q <= 1'b0;
        underrun_q <= 1'b0;
        if (!rst_n) begin
            cnt_q <= 4'h0;
            resend_q <= 1'b0;
        end else if (tx_resend_q || tx_reply_q) begin
            cnt_q <= SEND_DLY[3:0];
            resend_q <= tx_resend_q;
        end else if (on_air) begin
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h1 && resend_q) begin
                sent_q <= !fail_next;
                underrun_q <= fail_next;
            end
        end
    end
endmodule // rwre_medium_model
